//--- rlcx_pkg.sv
// Constants and types for the rotate-through-carry execution block
`default_nettype none
package rlcx_pkg;
	// Register byte offsets on APB
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_INSTR      = 8'h04;
	localparam logic [7:0]  OFF_WREG       = 8'h08;
	localparam logic [7:0]  OFF_STATUS     = 8'h0c;
	localparam logic [7:0]  OFF_BANKSEL    = 8'h10;
	localparam logic [7:0]  OFF_FSR2       = 8'h14;
	localparam logic [7:0]  OFF_PC         = 8'h18;
	localparam logic [7:0]  OFF_STACK      = 8'h1c;
	localparam logic [7:0]  OFF_MADDR      = 8'h20;
	localparam logic [7:0]  OFF_MDATA      = 8'h24;
	// Control register fields
	localparam int          CTRL_EXT       = 0;
	localparam int          CTRL_BUSY      = 1;
	localparam int          CTRL_ILLEGAL   = 2;
	localparam int          CTRL_UNDERFLOW = 3;
	localparam int          CTRL_OVERFLOW  = 4;
	// Status register fields
	localparam int          STAT_C         = 0;
	localparam int          STAT_Z         = 2;
	localparam int          STAT_N         = 4;
	// Opcode patterns
	localparam logic [5:0]  ROT_OPC        = 6'h0d;
	localparam logic [14:0] RET_OPC        = 15'h0009;
	// Address resolution
	localparam logic [7:0]  INDEX_MAX      = 8'h5f;
	localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
	localparam logic [3:0]  LOW_BANK       = 4'h0;
	localparam logic [3:0]  HIGH_BANK      = 4'hf;
	localparam int          MEM_DEPTH      = 4096;
	localparam int          STACK_DEPTH    = 31;
	localparam logic [4:0]  STACK_FULL     = 5'h1f;
	// Four clock phases per instruction cycle
	localparam logic [1:0]  PH_Q1          = 2'h0;
	localparam logic [1:0]  PH_Q2          = 2'h1;
	localparam logic [1:0]  PH_Q3          = 2'h2;
	localparam logic [1:0]  PH_Q4          = 2'h3;
	// Reset values
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [15:0] RST_OPCODE     = 16'h0000;
	localparam logic [20:0] RST_PC         = 21'h000000;
	localparam logic [11:0] RST_ADDR       = 12'h000;
	localparam logic [4:0]  RST_PTR        = 5'h00;

	typedef enum {ST_IDLE, ST_EXEC} rlcx_state_t;

	typedef struct packed {
		logic       dest;
		logic       bank;
		logic [7:0] file;
	} rlcx_fileop_t;

	typedef struct packed {
		logic neg;
		logic zero;
		logic carry;
	} rlcx_flags_t;
endpackage
`default_nettype wire

//--- rlcx_rotate_alu.sv
// Rotate-left-through-carry datapath with flag generation
`default_nettype none
module rlcx_rotate_alu (
	input  wire logic [7:0]           operand, // Byte read from the file register
	input  wire logic                 carryIn, // Carry before the rotate
	output logic [7:0]                result,  // Rotated byte
	output var rlcx_pkg::rlcx_flags_t flags    // Carry, negative and zero after the rotate
);
	assign result = {operand[6:0], carryIn};
	assign flags  = {result[7], result == 8'h00, operand[7]};
endmodule
`default_nettype wire

//--- rlcx_rotate_exec.sv
// Execution block for rotate-left-through-carry and subroutine return
// Overview of operation
// - Rotate left; carry in bit0, bit7 out
// - Destination bit 0 writes result to accumulator
// - Destination bit 1 writes back to register
// - Bank bit 0 uses access bank: low bank below 0x60, bank 15 from 0x60
// - Bank bit 1 combines bank select, address
// - Extended set, bank 0, f<=95: indexed offset
// - Return pops stack, loads PC from top
`default_nettype none
module rlcx_rotate_exec (
	input  wire logic        clk,     // 125 MHz core clock
	input  wire logic        rst,     // Synchronous reset, active high
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB access phase
	input  wire logic        pwrite,  // APB write direction
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	input  wire logic [3:0]  pstrb,   // APB byte lane strobes
	output logic [31:0]      prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr  // APB error on unmapped address
);
	rlcx_pkg::rlcx_state_t stateReg, stateNext;
	logic [1:0]            qReg, qNext;
	logic                  cycReg, cycNext;
	logic [15:0]           opcodeReg, opcodeNext;
	logic                  extEnReg, extEnNext;
	logic                  illegalReg, illegalNext;
	logic                  underReg, underNext;
	logic                  overReg, overNext;
	logic [7:0]            wReg, wNext;
	rlcx_pkg::rlcx_flags_t flagsReg, flagsNext;
	rlcx_pkg::rlcx_flags_t pendFlagsReg, pendFlagsNext;
	logic [3:0]            bankSelReg, bankSelNext;
	logic [11:0]           fsr2Reg, fsr2Next;
	logic [20:0]           pcReg, pcNext;
	logic [4:0]            ptrReg, ptrNext;
	logic [11:0]           maddrReg, maddrNext;
	logic [7:0]            operandReg, operandNext;
	logic [7:0]            resultReg, resultNext;
	logic                  readyReg, readyNext;
	logic [31:0]           rdataReg, rdataNext;

	logic [7:0]            fileMem [0:rlcx_pkg::MEM_DEPTH-1];
	logic [20:0]           retStack [0:rlcx_pkg::STACK_DEPTH-1];

	logic                  memWe;
	logic [11:0]           memWaddr;
	logic [7:0]            memWdata;
	logic                  pushWe;
	logic                  busy;
	logic                  apbWrite;
	logic                  mapped;
	logic                  isRot;
	logic                  isRet;
	logic                  indexed;
	logic [11:0]           opAddr;
	logic [20:0]           topEntry;
	logic [31:0]           wMerged;
	logic [31:0]           readMux;
	logic [7:0]            aluResult;
	rlcx_pkg::rlcx_flags_t aluFlags;
	rlcx_pkg::rlcx_fileop_t fileOp;

	function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	rlcx_rotate_alu u_alu (
		.operand (operandReg),
		.carryIn (flagsReg.carry),
		.result  (aluResult),
		.flags   (aluFlags)
	);

	assign busy     = stateReg == rlcx_pkg::ST_EXEC;
	// Ready only after a cycle with psel high and the block idle, so read data never shows a half-executed state
	assign pready   = psel & penable & readyReg;
	assign apbWrite = pready & pwrite;
	assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= rlcx_pkg::OFF_MDATA);
	assign pslverr  = pready & ~mapped;
	assign prdata   = rdataReg;
	assign fileOp   = opcodeReg[9:0];
	assign isRot    = opcodeReg[15:10] == rlcx_pkg::ROT_OPC;
	assign isRet    = opcodeReg[15:1] == rlcx_pkg::RET_OPC;
	assign indexed  = ~fileOp.bank & extEnReg & (fileOp.file <= rlcx_pkg::INDEX_MAX);
	assign topEntry = (ptrReg == rlcx_pkg::RST_PTR) ? rlcx_pkg::RST_PC : retStack[ptrReg - 5'h01];

	// Operand address resolution
	always_comb begin
		if (fileOp.bank) begin
			opAddr = {bankSelReg, fileOp.file};
		end else if (indexed) begin
			opAddr = fsr2Reg + {4'h0, fileOp.file};
		end else if (fileOp.file < rlcx_pkg::ACCESS_SPLIT) begin
			opAddr = {rlcx_pkg::LOW_BANK, fileOp.file};
		end else begin
			opAddr = {rlcx_pkg::HIGH_BANK, fileOp.file};
		end
	end

	always_comb begin
		case (paddr)
			rlcx_pkg::OFF_CTRL:   readMux = {27'h0000000, overReg, underReg, illegalReg, busy, extEnReg};
			rlcx_pkg::OFF_INSTR:  readMux = {16'h0000, opcodeReg};
			rlcx_pkg::OFF_WREG:   readMux = {24'h000000, wReg};
			rlcx_pkg::OFF_STATUS: readMux = {27'h0000000, flagsReg.neg, 1'b0, flagsReg.zero, 1'b0, flagsReg.carry};
			rlcx_pkg::OFF_BANKSEL: readMux = {28'h0000000, bankSelReg};
			rlcx_pkg::OFF_FSR2:   readMux = {20'h00000, fsr2Reg};
			rlcx_pkg::OFF_PC:     readMux = {11'h000, pcReg};
			rlcx_pkg::OFF_STACK:  readMux = {27'h0000000, ptrReg};
			rlcx_pkg::OFF_MADDR:  readMux = {20'h00000, maddrReg};
			rlcx_pkg::OFF_MDATA:  readMux = {24'h000000, fileMem[maddrReg]};
			default:              readMux = 32'h00000000;
		endcase
	end

	// Next-state logic for bus, registers and the execution sequencer
	always_comb begin
		stateNext     = stateReg;
		qNext         = qReg;
		cycNext       = cycReg;
		opcodeNext    = opcodeReg;
		extEnNext     = extEnReg;
		illegalNext   = illegalReg;
		underNext     = underReg;
		overNext      = overReg;
		wNext         = wReg;
		flagsNext     = flagsReg;
		pendFlagsNext = pendFlagsReg;
		bankSelNext   = bankSelReg;
		fsr2Next      = fsr2Reg;
		pcNext        = pcReg;
		ptrNext       = ptrReg;
		maddrNext     = maddrReg;
		operandNext   = operandReg;
		resultNext    = resultReg;
		memWe         = 1'b0;
		memWaddr      = maddrReg;
		memWdata      = pwdata[7:0];
		pushWe        = 1'b0;
		wMerged       = mergeLanes(readMux, pwdata, pstrb);
		rdataNext     = psel ? readMux : rdataReg;
		readyNext     = psel & ~busy & ~(apbWrite && paddr == rlcx_pkg::OFF_INSTR);

		if (apbWrite && mapped) begin
			case (paddr)
				rlcx_pkg::OFF_CTRL: begin
					extEnNext = wMerged[rlcx_pkg::CTRL_EXT];
					// Sticky flags clear by writing one
					illegalNext = illegalReg & ~(pstrb[0] & pwdata[rlcx_pkg::CTRL_ILLEGAL]);
					underNext   = underReg & ~(pstrb[0] & pwdata[rlcx_pkg::CTRL_UNDERFLOW]);
					overNext    = overReg & ~(pstrb[0] & pwdata[rlcx_pkg::CTRL_OVERFLOW]);
				end
				rlcx_pkg::OFF_INSTR: begin
					opcodeNext = wMerged[15:0];
					stateNext  = rlcx_pkg::ST_EXEC;
					qNext      = rlcx_pkg::PH_Q1;
					cycNext    = 1'b0;
				end
				rlcx_pkg::OFF_WREG:   wNext = wMerged[7:0];
				rlcx_pkg::OFF_STATUS: flagsNext = {wMerged[rlcx_pkg::STAT_N], wMerged[rlcx_pkg::STAT_Z],
					wMerged[rlcx_pkg::STAT_C]};
				rlcx_pkg::OFF_BANKSEL: bankSelNext = wMerged[3:0];
				rlcx_pkg::OFF_FSR2:   fsr2Next = wMerged[11:0];
				rlcx_pkg::OFF_PC:     pcNext = wMerged[20:0];
				rlcx_pkg::OFF_STACK: begin
					if (ptrReg == rlcx_pkg::STACK_FULL) begin
						overNext = 1'b1;
					end else begin
						pushWe  = 1'b1;
						ptrNext = ptrReg + 5'h01;
					end
				end
				rlcx_pkg::OFF_MADDR:  maddrNext = wMerged[11:0];
				rlcx_pkg::OFF_MDATA:  memWe = 1'b1;
				default:              memWe = 1'b0;
			endcase
		end

		if (busy) begin
			qNext = qReg + 2'h1;
			case (qReg)
				rlcx_pkg::PH_Q2: operandNext = fileMem[opAddr];
				rlcx_pkg::PH_Q3: begin
					resultNext    = aluResult;
					pendFlagsNext = aluFlags;
				end
				rlcx_pkg::PH_Q4: begin
					if (isRot) begin
						if (fileOp.dest) begin
							memWe    = 1'b1;
							memWaddr = opAddr;
							memWdata = resultReg;
						end else begin
							wNext = resultReg;
						end
						flagsNext = pendFlagsReg;
						stateNext = rlcx_pkg::ST_IDLE;
					end else if (isRet) begin
						// Second instruction cycle of a return is a no-operation
						if (!cycReg) begin
							pcNext = topEntry;
							if (ptrReg == rlcx_pkg::RST_PTR) begin
								underNext = 1'b1;
							end else begin
								ptrNext = ptrReg - 5'h01;
							end
							cycNext = 1'b1;
						end else begin
							stateNext = rlcx_pkg::ST_IDLE;
						end
					end else begin
						illegalNext = 1'b1;
						stateNext   = rlcx_pkg::ST_IDLE;
					end
				end
				default: operandNext = operandReg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stateReg     <= rlcx_pkg::ST_IDLE;
			qReg         <= rlcx_pkg::PH_Q1;
			cycReg       <= 1'b0;
			opcodeReg    <= rlcx_pkg::RST_OPCODE;
			extEnReg     <= 1'b0;
			illegalReg   <= 1'b0;
			underReg     <= 1'b0;
			overReg      <= 1'b0;
			wReg         <= rlcx_pkg::RST_BYTE;
			flagsReg     <= 3'h0;
			pendFlagsReg <= 3'h0;
			bankSelReg   <= 4'h0;
			fsr2Reg      <= rlcx_pkg::RST_ADDR;
			pcReg        <= rlcx_pkg::RST_PC;
			ptrReg       <= rlcx_pkg::RST_PTR;
			maddrReg     <= rlcx_pkg::RST_ADDR;
			operandReg   <= rlcx_pkg::RST_BYTE;
			resultReg    <= rlcx_pkg::RST_BYTE;
			readyReg     <= 1'b0;
			rdataReg     <= 32'h00000000;
		end else begin
			stateReg     <= stateNext;
			qReg         <= qNext;
			cycReg       <= cycNext;
			opcodeReg    <= opcodeNext;
			extEnReg     <= extEnNext;
			illegalReg   <= illegalNext;
			underReg     <= underNext;
			overReg      <= overNext;
			wReg         <= wNext;
			flagsReg     <= flagsNext;
			pendFlagsReg <= pendFlagsNext;
			bankSelReg   <= bankSelNext;
			fsr2Reg      <= fsr2Next;
			pcReg        <= pcNext;
			ptrReg       <= ptrNext;
			maddrReg     <= maddrNext;
			operandReg   <= operandNext;
			resultReg    <= resultNext;
			readyReg     <= readyNext;
			rdataReg     <= rdataNext;
		end
	end

	// Storage arrays are not reset; software initialises them
	always_ff @(posedge clk) begin
		if (memWe) begin
			fileMem[memWaddr] <= memWdata;
		end
		if (pushWe) begin
			retStack[ptrReg] <= pwdata[20:0];
		end
	end

	logic rotQ4;
	assign rotQ4 = busy && isRot && qReg == rlcx_pkg::PH_Q4;

	a_rot_carry: assert property (@(posedge clk) disable iff (rst)
		rotQ4 |=> flagsReg.carry == $past(operandReg[7], 1))
		else $error("Carry not taken from old bit 7");
	a_rot_wreg: assert property (@(posedge clk) disable iff (rst)
		(busy && isRot && qReg == rlcx_pkg::PH_Q3 && !fileOp.dest) |=>
		!memWe ##1 wReg == $past({operandReg[6:0], flagsReg.carry}, 2))
		else $error("Accumulator destination wrong or file register touched");
	a_rot_writeback: assert property (@(posedge clk) disable iff (rst)
		(rotQ4 && fileOp.dest) |-> memWe && memWaddr == opAddr && memWdata == resultReg)
		else $error("Write-back to file register missing");
	a_access_bank: assert property (@(posedge clk) disable iff (rst)
		(busy && isRot && !fileOp.bank && !indexed) |->
		opAddr == ((fileOp.file < 8'h60) ? {4'h0, fileOp.file} : {4'hf, fileOp.file}))
		else $error("Shared low bank address wrong");
	a_bank_select: assert property (@(posedge clk) disable iff (rst)
		(busy && isRot && fileOp.bank) |-> opAddr == {bankSelReg, fileOp.file})
		else $error("Banked address wrong");
	a_indexed_addr: assert property (@(posedge clk) disable iff (rst)
		(busy && isRot && !fileOp.bank && extEnReg && fileOp.file <= 8'h5f) |->
		opAddr == fsr2Reg + {4'h0, fileOp.file})
		else $error("Indexed literal offset address wrong");
	a_return_pop: assert property (@(posedge clk) disable iff (rst)
		(busy && isRet && !cycReg && qReg == rlcx_pkg::PH_Q4 && ptrReg != 5'h00) |=>
		pcReg == $past(topEntry, 1) && ptrReg == $past(ptrReg, 1) - 5'h01)
		else $error("Return did not pop the stack into the PC");
	a_rot_length: assert property (@(posedge clk) disable iff (rst)
		(apbWrite && paddr == rlcx_pkg::OFF_INSTR && pwdata[15:10] == 6'h0d && pstrb[1]) |=>
		busy [*4] ##1 !busy)
		else $error("Rotate did not take one instruction cycle");
	a_rot_flags: assert property (@(posedge clk) disable iff (rst)
		rotQ4 |=> flagsReg.neg == $past(resultReg[7], 1) && flagsReg.zero == ($past(resultReg, 1) == 8'h00))
		else $error("Negative or zero flag wrong after rotate");

	c_rot_to_w: cover property (@(posedge clk) disable iff (rst) rotQ4 && !fileOp.dest);
	c_rot_to_file: cover property (@(posedge clk) disable iff (rst) rotQ4 && fileOp.dest && fileOp.bank);
	c_rot_indexed: cover property (@(posedge clk) disable iff (rst) rotQ4 && indexed);
	c_return: cover property (@(posedge clk) disable iff (rst) busy && isRet && cycReg && qReg == rlcx_pkg::PH_Q4);
endmodule
`default_nettype wire

//--- tb_rotate_left_through_carry_exec.sv
// Self-checking bench for the rotate-through-carry execution block over APB
`default_nettype none
module tb_rotate_left_through_carry_exec;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          fails;
	int          samplesChecked;

	rlcx_rotate_exec uut (
		.clk     (clk),
		.rst     (rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("Comparisons: %0d, mismatches: %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One transfer; waits on pready, which stalls while an instruction runs; a hang is left to the watchdog
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hf;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h00000000, rd, err);
		check(rd, exp, what);
		check({31'h0, err}, 32'h00000000, "error flag on mapped read");
	endtask

	task automatic setmem(input logic [11:0] a, input logic [7:0] d);
		wreg(rlcx_pkg::OFF_MADDR, {20'h0, a});
		wreg(rlcx_pkg::OFF_MDATA, {24'h0, d});
	endtask

	task automatic memchk(input logic [11:0] a, input logic [7:0] exp, input string what);
		wreg(rlcx_pkg::OFF_MADDR, {20'h0, a});
		rchk(rlcx_pkg::OFF_MDATA, {24'h0, exp}, what);
	endtask

	// Access bank, result to accumulator; bank select must be ignored
	task automatic rotate_to_accumulator;
		wreg(rlcx_pkg::OFF_CTRL, 32'h00000000);
		wreg(rlcx_pkg::OFF_BANKSEL, 32'h00000005);
		setmem(12'h010, 8'he6);
		setmem(12'h510, 8'h11);
		wreg(rlcx_pkg::OFF_STATUS, 32'h00000000);
		wreg(rlcx_pkg::OFF_WREG, 32'h00000055);
		wreg(rlcx_pkg::OFF_INSTR, 32'h00003410);
		rchk(rlcx_pkg::OFF_WREG, 32'h000000cc, "accumulator after rotate");
		rchk(rlcx_pkg::OFF_STATUS, 32'h00000011, "carry and negative set");
		memchk(12'h010, 8'he6, "source left alone");
		setmem(12'hf80, 8'h01);
		wreg(rlcx_pkg::OFF_STATUS, 32'h00000001);
		wreg(rlcx_pkg::OFF_INSTR, 32'h00003480);
		rchk(rlcx_pkg::OFF_WREG, 32'h00000003, "upper access half, carry in");
		rchk(rlcx_pkg::OFF_STATUS, 32'h00000000, "carry out cleared");
	endtask

	// Banked operand written back; zero result
	task automatic rotate_write_back;
		wreg(rlcx_pkg::OFF_BANKSEL, 32'h00000003);
		setmem(12'h345, 8'h80);
		setmem(12'h045, 8'h5a);
		wreg(rlcx_pkg::OFF_STATUS, 32'h00000000);
		wreg(rlcx_pkg::OFF_WREG, 32'h00000077);
		wreg(rlcx_pkg::OFF_INSTR, 32'h00003745);
		memchk(12'h345, 8'h00, "banked register written back");
		rchk(rlcx_pkg::OFF_STATUS, 32'h00000005, "carry and zero set");
		rchk(rlcx_pkg::OFF_WREG, 32'h00000077, "accumulator untouched");
		memchk(12'h045, 8'h5a, "bank zero untouched");
	endtask

	// Indexed offset at the last qualifying address, then the first that is not
	task automatic rotate_indexed;
		wreg(rlcx_pkg::OFF_CTRL, 32'h00000001);
		wreg(rlcx_pkg::OFF_FSR2, 32'h00000200);
		setmem(12'h25f, 8'h41);
		setmem(12'h05f, 8'h00);
		wreg(rlcx_pkg::OFF_STATUS, 32'h00000001);
		wreg(rlcx_pkg::OFF_INSTR, 32'h0000365f);
		memchk(12'h25f, 8'h83, "indexed operand rotated");
		memchk(12'h05f, 8'h00, "low bank not used");
		rchk(rlcx_pkg::OFF_STATUS, 32'h00000010, "negative only");
		setmem(12'hf60, 8'h02);
		wreg(rlcx_pkg::OFF_STATUS, 32'h00000000);
		wreg(rlcx_pkg::OFF_INSTR, 32'h00003660);
		memchk(12'hf60, 8'h04, "address above index range");
		wreg(rlcx_pkg::OFF_CTRL, 32'h00000000);
	endtask

	// Two pops in order, then a pop of the empty stack
	task automatic subroutine_return;
		wreg(rlcx_pkg::OFF_STACK, 32'h00012345);
		wreg(rlcx_pkg::OFF_STACK, 32'h0000abcd);
		wreg(rlcx_pkg::OFF_STATUS, 32'h00000015);
		wreg(rlcx_pkg::OFF_INSTR, 32'h00000012);
		rchk(rlcx_pkg::OFF_PC, 32'h0000abcd, "pc from top entry");
		rchk(rlcx_pkg::OFF_STACK, 32'h00000001, "pointer after pop");
		wreg(rlcx_pkg::OFF_INSTR, 32'h00000013);
		rchk(rlcx_pkg::OFF_PC, 32'h00012345, "pc from older entry");
		rchk(rlcx_pkg::OFF_STACK, 32'h00000000, "stack empty");
		rchk(rlcx_pkg::OFF_STATUS, 32'h00000015, "flags kept over return");
		wreg(rlcx_pkg::OFF_INSTR, 32'h00000012);
		rchk(rlcx_pkg::OFF_CTRL, 32'h00000008, "underflow flagged");
		wreg(rlcx_pkg::OFF_CTRL, 32'h00000008);
		rchk(rlcx_pkg::OFF_CTRL, 32'h00000000, "underflow cleared");
		repeat (32) wreg(rlcx_pkg::OFF_STACK, 32'h00000000);
		rchk(rlcx_pkg::OFF_CTRL, 32'h00000010, "overflow flagged");
		rchk(rlcx_pkg::OFF_STACK, 32'h0000001f, "pointer held at full");
		wreg(rlcx_pkg::OFF_CTRL, 32'h00000010);
	endtask

	// Neighbouring opcode is not this rotate; unmapped and misaligned accesses
	task automatic illegal_and_unmapped;
		logic [31:0] rd;
		logic        err;
		wreg(rlcx_pkg::OFF_WREG, 32'h00000012);
		wreg(rlcx_pkg::OFF_INSTR, 32'h00003012);
		rchk(rlcx_pkg::OFF_WREG, 32'h00000012, "other opcode does nothing");
		rchk(rlcx_pkg::OFF_CTRL, 32'h00000004, "illegal opcode flagged");
		wreg(rlcx_pkg::OFF_CTRL, 32'h00000004);
		apb(1'b0, 8'h28, 32'h00000000, rd, err);
		check({31'h0, err}, 32'h00000001, "unmapped error");
		check(rd, 32'h00000000, "unmapped reads zero");
		apb(1'b1, 8'h0a, 32'h000000ff, rd, err);
		check({31'h0, err}, 32'h00000001, "misaligned error");
		rchk(rlcx_pkg::OFF_WREG, 32'h00000012, "misaligned write ignored");
	endtask

	initial begin
		fails = 0;
		samplesChecked = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rotate_to_accumulator();
		rotate_write_back();
		rotate_indexed();
		subroutine_return();
		illegal_and_unmapped();
		tally_and_finish();
	end

	// Whole run needs a few hundred cycles; this leaves a wide margin
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("ERROR at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
